// File: hdl/ibr_port.sv
// imu burst read and configuration serial port with ahb-lite side
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - wide burst, select 0: flags, rate xyz low/high, accel xyz, temp, count, sum
// - wide burst, select 1: flags, delta angle xyz, delta velocity xyz, temp, count, sum
// - last word is the 16-bit sum of all prior word bytes
// - nonzero filter setting N adds N sample cycles of group delay
// - nonzero decimation D adds (D+1)/2 sample cycles of group delay
// - config registers are 16 bits, each byte at its own address
// - write word: bit 15 set, seven-bit byte address, data in low byte
// - filter control low byte at 0x5c, high byte at 0x5d
// - after reset flash content is copied into sram, accesses use sram
// - serial writes change sram only, flash waits for the save command
// - bit 3 of global command saves all backed settings to flash
// - command 0x6800 with select held low starts a burst
// - scaled sync sends the timestamp in place of the sample counter
// - register read: address word, contents return in the next word
// - spi mode 3, msb first, 16-bit words, device is slave
module ibr_port import ibr_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  output logic             irq
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic              sclk_m;
    logic              sclk_s;
    logic              sclk_d;
    logic              cs_m;
    logic              cs_s;
    logic              mosi_m;
    logic              mosi_s;
    logic [3:0]        bitc;
    logic [15:0]       rx;
    logic [15:0]       tx;
    logic              miso;
    logic              miso_oe;
    ibr_sp_t           mode;
    logic [3:0]        bpos;
    logic [3:0]        blast;
    logic              bdone;
    logic [15:0]       chk;
    logic [14:0][15:0] snap;
    logic              cw_we;
    logic [6:0]        cw_addr;
    logic [7:0]        cw_data;
    logic              save_req;
    logic [NEV-1:0]    ev;
    logic [NEV-1:0]    mask;
    logic              irq;
    logic              wpend;
    logic [11:0]       waddr;
    logic [31:0]       hrdata;
    logic              hready;
    logic              hresp;
    logic [15:0]       gd;
  } ibr_st_t;

  ibr_st_t           s;
  ibr_st_t           next_s;
  logic [7:0]        sram [CFG_DEPTH];
  logic [15:0]       live [S_COUNT];
  logic [14:0][15:0] snap_src;
  logic [15:0]       w_word;
  logic [6:0]        w_addr;
  logic              rise;
  logic              fall;
  logic              w_end;
  logic              wide;
  logic              sel;
  logic              sync;
  logic [15:0]       filt;
  logic [15:0]       dec;
  ibr_nvm_if         nv ();

  ibr_nvm u_nvm (
    .hclk    (hclk),
    .hresetn (hresetn),
    .nv      (nv)
  );

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // live word that feeds burst position k
  function automatic logic [4:0] burst_src(input int k, input logic wd,
                                           input logic sl, input logic sy);
    logic [4:0] base;
    base = sl ? S_DELTA : S_RATE;
    if (k == 0) return S_DIAG;
    if (wd) begin
      if (k <= W_DATA) return base + 5'(k - 1);
      if (k == W_TEMP) return S_TEMP;
    end else begin
      if (k <= N_HIGH) return base + 5'(2 * k - 1);
      if (k == N_TEMP) return S_TEMP;
      if (k != N_CNT) return S_DIAG;
    end
    return sy ? S_TSTAMP : S_CNTR;
  endfunction

  // ahb read mux
  function automatic logic [31:0] rd_mux(input logic [11:0] ad);
    logic [31:0] r;
    r = '0;
    if (ad == A_IRQ_STAT) r = 32'(s.ev);
    else if (ad == A_IRQ_MASK) r = 32'(s.mask);
    else if (ad == A_STATE) r = {30'h0, s.mode == SP_BURST, nv.busy};
    else if (ad == A_GDELAY) r = 32'(s.gd);
    else if (ad[11:7] == A_SAMPLE[11:7] && ad[6:2] < S_COUNT)
      r = 32'(live[ad[6:2]]);
    else if (ad[11:9] == A_CFG[11:9]) r = 32'(sram[ad[8:2]]);
    return r;
  endfunction

  assign rise   = s.sclk_s & ~s.sclk_d;
  assign fall   = ~s.sclk_s & s.sclk_d;
  assign w_word = {s.rx[14:0], s.mosi_s};
  assign w_addr = w_word[14:8];
  assign w_end  = ~s.cs_s & rise & (s.bitc == BIT_LAST);
  assign wide   = sram[MODE_LO][MODE_WIDE];
  assign sel    = sram[MODE_LO][MODE_SEL];
  assign sync   = sram[MODE_LO][MODE_SYNC];
  assign filt   = {sram[FILT_HI], sram[FILT_LO]};
  assign dec    = {sram[DEC_HI], sram[DEC_LO]};

  // burst order picked from the live words per position
  for (genvar k = 0; k < SNAP_N; k++) begin : g_snap
    assign snap_src[k] = live[burst_src(k, wide, sel, sync)];
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    logic [NEV-1:0] set_ev;
    logic [NEV-1:0] clr_ev;
    set_ev          = '0;
    clr_ev          = '0;
    next_s          = s;
    // two-flop synchronisers for the link pins
    next_s.sclk_m   = spi_sclk;
    next_s.sclk_s   = s.sclk_m;
    next_s.sclk_d   = s.sclk_s;
    next_s.cs_m     = spi_cs_n;
    next_s.cs_s     = s.cs_m;
    next_s.mosi_m   = spi_mosi;
    next_s.mosi_s   = s.mosi_m;
    next_s.miso_oe  = ~s.cs_s;
    next_s.cw_we    = 1'b0;
    next_s.save_req = 1'b0;
    if (s.cs_s) begin
      // deselect aborts a word and any burst; a read reply is kept
      next_s.bitc = '0;
      if (s.mode == SP_BURST) begin
        next_s.mode  = SP_CMD;
        next_s.bdone = 1'b0;
        next_s.tx    = '0;
      end
    end else begin
      if (fall) next_s.miso = s.tx[~s.bitc];
      if (rise) begin
        next_s.rx   = w_word;
        next_s.bitc = s.bitc + 4'h1;
      end
      if (w_end && s.mode == SP_BURST) begin
        if (s.bdone) begin
          next_s.mode       = SP_CMD;
          next_s.bdone      = 1'b0;
          next_s.tx         = '0;
          set_ev[EV_BURST]  = 1'b1;
        end else if (s.bpos == s.blast) begin
          next_s.tx    = s.chk;
          next_s.bdone = 1'b1;
        end else begin
          next_s.tx   = s.snap[s.bpos];
          next_s.chk  = s.chk + ibr_bsum(s.snap[s.bpos]);
          next_s.bpos = s.bpos + 4'h1;
        end
      end else if (w_end && w_word[WR_BIT]) begin
        next_s.tx = '0;
        if (w_addr == GCMD_LO) begin
          next_s.save_req = w_word[GCMD_SAVE] & ~nv.busy;
        end else if (!nv.busy) begin
          next_s.cw_we    = 1'b1;
          next_s.cw_addr  = w_addr;
          next_s.cw_data  = w_word[7:0];
          set_ev[EV_CFG]  = 1'b1;
        end
      end else if (w_end && w_word == BURST_CMD) begin
        next_s.mode  = SP_BURST;
        next_s.snap  = snap_src;
        next_s.blast = wide ? WIDE_CHK : NARROW_CHK;
        next_s.bpos  = BPOS_FIRST;
        next_s.bdone = 1'b0;
        next_s.tx    = snap_src[0];
        next_s.chk   = ibr_bsum(snap_src[0]);
      end else if (w_end) begin
        next_s.tx = {sram[{w_addr[6:1], 1'b1}], sram[{w_addr[6:1], 1'b0}]};
      end
    end
    set_ev[EV_SAVE] = nv.save_done;
    set_ev[EV_LOAD] = nv.load_done;
    // ahb data phase of a write
    next_s.wpend = 1'b0;
    if (s.wpend && s.waddr == A_IRQ_STAT) clr_ev = hwdata[NEV-1:0];
    if (s.wpend && s.waddr == A_IRQ_MASK) next_s.mask = hwdata[NEV-1:0];
    // ahb address phase
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        next_s.wpend = 1'b1;
        next_s.waddr = haddr;
      end else begin
        next_s.hrdata = rd_mux(haddr);
      end
    end
    // sticky events, a new event beats a clear in the same cycle
    next_s.ev  = (s.ev & ~clr_ev) | set_ev;
    next_s.irq = |(s.ev & s.mask);
    next_s.gd  = filt + 16'((17'(dec) + 17'h1) >> 1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s        <= '0;
      s.sclk_m <= 1'b1;
      s.sclk_s <= 1'b1;
      s.sclk_d <= 1'b1;
      s.cs_m   <= 1'b1;
      s.cs_s   <= 1'b1;
      s.hready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // sram: loader first, then serial byte writes
  always_ff @(posedge hclk) begin
    if (nv.ld_we) begin
      sram[nv.addr] <= nv.ld_data;
    end else if (s.cw_we) begin
      sram[s.cw_addr] <= s.cw_data;
    end
  end

  // live sample words written by the sensor core over ahb
  always_ff @(posedge hclk) begin
    if (s.wpend && s.waddr[11:7] == A_SAMPLE[11:7]
        && s.waddr[6:2] < S_COUNT) begin
      live[s.waddr[6:2]] <= hwdata[15:0];
    end
  end

  assign nv.save_req  = s.save_req;
  assign nv.pgm_we    = s.wpend && s.waddr == A_FLASH_PGM;
  assign nv.pgm_addr  = hwdata[PGM_AH:PGM_AL];
  assign nv.pgm_data  = hwdata[7:0];
  assign nv.rd_data   = sram[nv.addr];
  assign hrdata       = s.hrdata;
  assign hreadyout    = s.hready;
  assign hresp        = s.hresp;
  assign spi_miso     = s.miso;
  assign spi_miso_oe  = s.miso_oe;
  assign irq          = s.irq;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  function automatic logic [15:0] chk_ref(input logic [14:0][15:0] sn,
                                          input logic [3:0] n);
    logic [15:0] acc;
    acc = '0;
    for (int i = 0; i < SNAP_N; i++) begin
      if (4'(i) < n) acc = acc + ibr_bsum(sn[i]);
    end
    return acc;
  endfunction

  sequence s_burst_go;
    w_end && s.mode == SP_CMD && w_word == BURST_CMD;
  endsequence
  sequence s_cfg_wr;
    w_end && s.mode == SP_CMD && w_word[WR_BIT] && !nv.busy;
  endsequence

  property p_order_rate;
    s_burst_go ##0 (wide && !sel) |=> s.snap[1] == $past(live[S_RATE])
      && s.snap[W_TEMP] == $past(live[S_TEMP]);
  endproperty
  a_order_rate: assert property (p_order_rate)
    else $error("rate burst order wrong");

  property p_order_delta;
    s_burst_go ##0 (wide && sel) |=> s.snap[1] == $past(live[S_DELTA]);
  endproperty
  a_order_delta: assert property (p_order_delta)
    else $error("delta burst order wrong");

  property p_stamp;
    s_burst_go ##0 (wide && sync) |=> s.snap[W_CNT] == $past(live[S_TSTAMP]);
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("timestamp not in burst");

  property p_chk;
    w_end && s.mode == SP_BURST && !s.bdone && s.bpos == s.blast
      |=> s.tx == chk_ref(s.snap, s.blast);
  endproperty
  a_chk: assert property (p_chk)
    else $error("burst checksum wrong");

  property p_start;
    s_burst_go |=> s.mode == SP_BURST && s.tx == s.snap[0];
  endproperty
  a_start: assert property (p_start)
    else $error("burst did not start");

  property p_latch;
    s.mode == SP_BURST && $past(s.mode) == SP_BURST |-> $stable(s.snap);
  endproperty
  a_latch: assert property (p_latch)
    else $error("burst snapshot changed");

  property p_wr;
    s_cfg_wr ##0 (w_addr != GCMD_LO)
      |=> s.cw_we ##1 sram[$past(w_addr, 2)] == $past(w_word[7:0], 2);
  endproperty
  a_wr: assert property (p_wr)
    else $error("byte write lost");

  property p_filt;
    s.cw_we && s.cw_addr == FILT_HI |=> filt[15:8] == $past(s.cw_data);
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter byte misplaced");

  property p_gd;
    filt == '0 |=> s.gd == ($past(dec) >> 1) + {15'h0, $past(dec[0])};
  endproperty
  a_gd: assert property (p_gd)
    else $error("group delay wrong");

  property p_save;
    s_cfg_wr ##0 (w_addr == GCMD_LO && w_word[GCMD_SAVE])
      |=> s.save_req ##1 nv.busy;
  endproperty
  a_save: assert property (p_save)
    else $error("save not started");

  property p_mode3;
    $changed(s.miso) |-> $past(fall);
  endproperty
  a_mode3: assert property (p_mode3)
    else $error("miso moved off a falling edge");
endmodule

// File: hdl/ibr_pkg.sv
// constants and types of the imu burst read and config port
package ibr_pkg;
  // -------------------------------------------------------------
  // ahb register map (byte addresses)
  // -------------------------------------------------------------
  localparam logic [11:0] A_IRQ_STAT  = 12'h000;
  localparam logic [11:0] A_IRQ_MASK  = 12'h004;
  localparam logic [11:0] A_STATE     = 12'h008;
  localparam logic [11:0] A_GDELAY    = 12'h00c;
  localparam logic [11:0] A_FLASH_PGM = 12'h010;
  localparam logic [11:0] A_SAMPLE    = 12'h080;
  localparam logic [11:0] A_CFG       = 12'h200;
  localparam int          PGM_AH      = 14;
  localparam int          PGM_AL      = 8;
  // -------------------------------------------------------------
  // configuration byte space
  // -------------------------------------------------------------
  localparam int          CFG_AW    = 7;
  localparam int          CFG_DEPTH = 128;
  localparam logic [6:0]  CFG_LAST  = 7'h7f;
  localparam logic [6:0]  FILT_LO   = 7'h5c;
  localparam logic [6:0]  FILT_HI   = 7'h5d;
  localparam logic [6:0]  MODE_LO   = 7'h60;
  localparam logic [6:0]  DEC_LO    = 7'h64;
  localparam logic [6:0]  DEC_HI    = 7'h65;
  localparam logic [6:0]  GCMD_LO   = 7'h68;
  localparam int          MODE_SYNC = 0;
  localparam int          MODE_SEL  = 1;
  localparam int          MODE_WIDE = 2;
  localparam int          GCMD_SAVE = 3;
  // -------------------------------------------------------------
  // serial command words
  // -------------------------------------------------------------
  localparam int          WR_BIT    = 15;
  localparam logic [15:0] BURST_CMD = 16'h6800;
  localparam logic [3:0]  BIT_LAST  = 4'hf;
  // -------------------------------------------------------------
  // live sample words and burst positions
  // -------------------------------------------------------------
  localparam logic [4:0]  S_DIAG    = 5'h00;
  localparam logic [4:0]  S_RATE    = 5'h01;
  localparam logic [4:0]  S_DELTA   = 5'h0d;
  localparam logic [4:0]  S_TEMP    = 5'h19;
  localparam logic [4:0]  S_CNTR    = 5'h1a;
  localparam logic [4:0]  S_TSTAMP  = 5'h1b;
  localparam logic [4:0]  S_COUNT   = 5'h1c;
  localparam int          SNAP_N    = 15;
  localparam int          W_DATA    = 12;
  localparam int          W_TEMP    = 13;
  localparam int          W_CNT     = 14;
  localparam int          N_HIGH    = 6;
  localparam int          N_TEMP    = 7;
  localparam int          N_CNT     = 8;
  localparam logic [3:0]  WIDE_CHK  = 4'hf;
  localparam logic [3:0]  NARROW_CHK = 4'h9;
  localparam logic [3:0]  BPOS_FIRST = 4'h1;
  // -------------------------------------------------------------
  // interrupt events
  // -------------------------------------------------------------
  localparam int          NEV       = 4;
  localparam int          EV_BURST  = 0;
  localparam int          EV_CFG    = 1;
  localparam int          EV_SAVE   = 2;
  localparam int          EV_LOAD   = 3;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic {SP_CMD, SP_BURST} ibr_sp_t;
  typedef enum logic [1:0] {NV_LOAD, NV_IDLE, NV_SAVE} ibr_nv_st_t;
  // unsigned sum of the two bytes of a word
  function automatic logic [15:0] ibr_bsum(input logic [15:0] w);
    return 16'(w[15:8]) + 16'(w[7:0]);
  endfunction
endpackage

// File: hdl/ibr_nvm_if.sv
// carrier between the serial port and the flash bank engine
`timescale 1ns/1ps
interface ibr_nvm_if import ibr_pkg::*;;
  logic              save_req;
  logic              pgm_we;
  logic [CFG_AW-1:0] pgm_addr;
  logic [7:0]        pgm_data;
  logic [CFG_AW-1:0] addr;
  logic [7:0]        rd_data;
  logic              ld_we;
  logic [7:0]        ld_data;
  logic              busy;
  logic              load_done;
  logic              save_done;
  modport port (output save_req, pgm_we, pgm_addr, pgm_data, rd_data,
                input  addr, ld_we, ld_data, busy, load_done, save_done);
  modport nvm  (input  save_req, pgm_we, pgm_addr, pgm_data, rd_data,
                output addr, ld_we, ld_data, busy, load_done, save_done);
endinterface

// File: hdl/ibr_nvm.sv
// flash bank with load-at-reset and save-on-command engine
`timescale 1ns/1ps
module ibr_nvm import ibr_pkg::*; (
  input  wire logic hclk,
  input  wire logic hresetn,
  ibr_nvm_if.nvm    nv
);
  // -------------------------------------------------------------
  // state and storage
  // -------------------------------------------------------------
  typedef struct packed {
    ibr_nv_st_t        st;
    logic [CFG_AW-1:0] addr;
    logic              ldone;
    logic              sdone;
  } ibr_nvs_t;

  ibr_nvs_t   s;
  ibr_nvs_t   next_s;
  logic [7:0] flash [CFG_DEPTH];
  logic       fl_we;
  logic [7:0] fl_mode;

  // walk all bytes on load after reset, and on save
  always_comb begin
    next_s       = s;
    next_s.ldone = 1'b0;
    next_s.sdone = 1'b0;
    case (s.st)
      NV_LOAD: begin
        next_s.addr = s.addr + 7'h1;
        if (s.addr == CFG_LAST) begin
          next_s.st    = NV_IDLE;
          next_s.ldone = 1'b1;
        end
      end
      NV_IDLE: begin
        if (nv.save_req) begin
          next_s.st   = NV_SAVE;
          next_s.addr = '0;
        end
      end
      NV_SAVE: begin
        next_s.addr = s.addr + 7'h1;
        if (s.addr == CFG_LAST) begin
          next_s.st    = NV_IDLE;
          next_s.sdone = 1'b1;
        end
      end
      default: next_s.st = NV_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // flash only changes on save or factory programming
  assign fl_we = (s.st == NV_SAVE) | nv.pgm_we;
  // mode byte watched so a serial write reaching flash shows up
  assign fl_mode = flash[MODE_LO];
  always_ff @(posedge hclk) begin
    if (s.st == NV_SAVE) begin
      flash[s.addr] <= nv.rd_data;
    end else if (nv.pgm_we) begin
      flash[nv.pgm_addr] <= nv.pgm_data;
    end
  end

  assign nv.addr      = s.addr;
  assign nv.ld_we     = (s.st == NV_LOAD);
  assign nv.ld_data   = flash[s.addr];
  assign nv.busy      = (s.st != NV_IDLE);
  assign nv.load_done = s.ldone;
  assign nv.save_done = s.sdone;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_load_walk;
    s.st == NV_LOAD && s.addr != CFG_LAST
      |=> s.st == NV_LOAD && s.addr == $past(s.addr) + 7'h1;
  endproperty
  a_load_walk: assert property (p_load_walk)
    else $error("load walk broke off");

  property p_flash_hold;
    !fl_we |=> $stable(fl_mode);
  endproperty
  a_flash_hold: assert property (p_flash_hold)
    else $error("flash written outside a save");

  property p_save_len;
    s.st == NV_IDLE && nv.save_req |=> (s.st == NV_SAVE)[*8] ##121 s.sdone;
  endproperty
  a_save_len: assert property (p_save_len)
    else $error("save did not cover all bytes");
endmodule

// File: testbench/ibr_host_model.sv
// host side serial master model, mode 3, 16-bit words
`timescale 1ns/1ps
module ibr_host_model (
  input  wire logic hclk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic last;
  // a released line never shows the last bit again
  wire  line = miso_oe ? miso : ~last;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
    last = 1'b0;
  end
  // select is held for the whole frame, a link period of gap each side
  task automatic sel(input logic on);
    repeat (8) @(posedge hclk);
    cs_n <= ~on;
    repeat (8) @(posedge hclk);
  endtask
  // words go back to back, data out on fall, sampled on rise, msb first
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      sclk  <= 1'b0;
      mosi  <= tx[i];
      repeat (4) @(posedge hclk);
      sclk  <= 1'b1;
      rx[i] = line;
      last  = line;
      repeat (4) @(posedge hclk);
    end
  endtask
endmodule

// File: testbench/imu_burst_read_and_config_port_test.sv
// self-checking bench of the burst read and configuration port
`timescale 1ns/1ps
module imu_burst_read_and_config_port_test import ibr_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, spi_sclk, spi_cs_n;
  logic spi_mosi, spi_miso, spi_miso_oe, irq, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, d;
  logic [15:0] sw [S_COUNT];
  int          n_mismatch, samples_checked;
  ibr_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .irq(irq));
  ibr_host_model u_host (.hclk(hclk), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi), .miso(spi_miso), .miso_oe(spi_miso_oe));
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin
      n_mismatch++;
      $display("ERROR %0t bus hang", $time);
      report_and_stop();
    end
  endtask
  // one single ahb-lite word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic poll(input logic [31:0] m);
    logic [31:0] r;
    for (int k = 0; k < 400; k++) begin
      ahb(1'b0, A_IRQ_STAT, 32'h0, r);
      if ((r & m) === m) return;
    end
    n_mismatch++;
    $display("ERROR %0t status wait ran out", $time);
    report_and_stop();
  endtask
  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    poll(32'h8);
  endtask
  task automatic ck_cfg(input logic [6:0] a, input logic [7:0] v);
    ahb(1'b0, A_CFG + {3'h0, a, 2'h0}, 32'h0, d);
    chk(d, {24'h0, v});
    chk(hresp, 32'h0);
  endtask
  task automatic spi(input logic [15:0] w0, input logic [15:0] exp1);
    logic [15:0] rx;
    u_host.sel(1'b1);
    u_host.word(w0, rx);
    if (!w0[WR_BIT]) begin
      u_host.word(16'h0000, rx);
      chk(rx, exp1);
    end
    u_host.sel(1'b0);
  endtask
  // burst with expected order and running byte sum
  task automatic burst(input logic [2:0] m);
    logic [15:0] rx, e, sum;
    int n, ix;
    n = m[MODE_WIDE] ? 16 : 10;
    sum = 16'h0000;
    u_host.sel(1'b1);
    u_host.word(BURST_CMD, rx);
    for (int k = 0; k < n; k++) begin
      u_host.word(16'h0000, rx);
      if (k == 0) ix = 0;
      else if (k == n - 3) ix = S_TEMP;
      else if (k == n - 2) ix = m[MODE_SYNC] ? S_TSTAMP : S_CNTR;
      else ix = (m[MODE_SEL] ? S_DELTA : S_RATE)
                + (m[MODE_WIDE] ? k - 1 : 2 * k - 1);
      e = (k == n - 1) ? sum : sw[ix];
      sum = sum + e[15:8] + e[7:0];
      chk(rx, e);
    end
    u_host.sel(1'b0);
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    n_mismatch = 0;
    samples_checked = 0;
    do_reset();
    for (int a = 0; a < CFG_DEPTH; a++)
      ahb(1'b1, A_FLASH_PGM, {17'h0, 7'(a),
          (7'(a) == MODE_LO) ? 8'h02 : 8'h00}, d);
    do_reset();
    ck_cfg(MODE_LO, 8'h02);
    ahb(1'b0, A_STATE, 32'h0, d);
    chk(d, 32'h0);
    chk(irq, 32'h0);
    ahb(1'b1, A_IRQ_MASK, 32'hf, d);
    repeat (2) @(posedge hclk);
    chk(irq, 32'h1);
    for (int i = 0; i < S_COUNT; i++) begin
      sw[i] = 16'(i * 16'h0b07 + 16'h2c35);
      ahb(1'b1, A_SAMPLE + 12'(4 * i), {16'h0, sw[i]}, d);
    end
    ahb(1'b0, A_SAMPLE + 12'h4, 32'h0, d);
    chk(d, {16'h0, sw[1]});
    spi({1'b1, FILT_LO, 8'h04}, 16'h0);
    spi({1'b1, FILT_HI, 8'h00}, 16'h0);
    ahb(1'b0, A_GDELAY, 32'h0, d);
    chk(d, 32'h4);
    ck_cfg(FILT_LO, 8'h04);
    spi({1'b1, DEC_LO, 8'h03}, 16'h0);
    spi({1'b1, DEC_HI, 8'h00}, 16'h0);
    ahb(1'b0, A_GDELAY, 32'h0, d);
    chk(d, 32'h6);
    for (int m = 0; m < 8; m++) begin
      ahb(1'b1, A_IRQ_STAT, 32'hf, d);
      spi({1'b1, MODE_LO, 5'h0, 3'(m)}, 16'h0);
      spi({1'b0, MODE_LO, 8'h00}, {13'h0, 3'(m)});
      burst(3'(m));
      poll(32'h1);
      ahb(1'b1, A_IRQ_STAT, 32'hf, d);
      repeat (2) @(posedge hclk);
      chk(irq, 32'h0);
    end
    do_reset();
    ck_cfg(MODE_LO, 8'h02);
    spi({1'b1, MODE_LO, 8'h05}, 16'h0);
    spi({1'b1, GCMD_LO, 8'h08}, 16'h0);
    poll(32'h4);
    do_reset();
    ck_cfg(MODE_LO, 8'h05);
    ahb(1'b0, 12'h100, 32'h0, d);
    chk(d, 32'h0);
    report_and_stop();
  end
endmodule
